//--- pkg/cmd_decoder_pkg.sv
package cmd_decoder_pkg;

    // ----------------------------------------------------------------
    // command word layout
    // ----------------------------------------------------------------
    localparam int WRITE_FLAG_POS    = 15;
    localparam int SELECT_MSB        = 14;
    localparam int SELECT_LSB        = 9;
    localparam int STACK_SELECT_POS  = 14;
    localparam int DATA_MSB          = 8;

    // ----------------------------------------------------------------
    // register select codes (lower five bits)
    // ----------------------------------------------------------------
    localparam logic [4:0] SEL_CONVERSION = 5'h00;
    localparam logic [4:0] SEL_RESERVED   = 5'h01;
    localparam logic [4:0] SEL_CONFIG     = 5'h02;
    localparam logic [4:0] SEL_CHANNEL    = 5'h03;
    localparam logic [4:0] SEL_RANGE_A1   = 5'h04;
    localparam logic [4:0] SEL_RANGE_B2   = 5'h07;
    localparam logic [4:0] SEL_STATUS     = 5'h08;

    // ----------------------------------------------------------------
    // configuration_control fields and reset
    // ----------------------------------------------------------------
    localparam int CFG_SELF_DETECT_POS = 7;
    localparam int CFG_BURST_POS       = 6;
    localparam int CFG_SEQ_POS         = 5;
    localparam int CFG_OS_MSB          = 4;
    localparam int CFG_OS_LSB          = 2;
    localparam int CFG_STATUS_POS      = 1;
    localparam int CFG_CHECKSUM_POS    = 0;
    localparam logic [6:0] CFG_RESET   = 7'h00;

    typedef struct packed {
        logic       write_flag;
        logic [5:0] register_select;
        logic [8:0] data;
    } command_word_s;

    typedef enum logic [1:0] {
        READ_NONE     = 2'h0,
        READ_REGISTER = 2'h1,
        READ_RESULT   = 2'h3,
        READ_STACK    = 2'h2
    } read_target_e;

    typedef struct packed {
        logic       burst_sequence_enable;
        logic       sequencer_enable;
        logic [2:0] oversampling_ratio_field;
        logic       status_append_enable;
        logic       checksum_append_enable;
    } config_s;

endpackage

//--- src/adc_register_command_decoder.sv
`timescale 1ns/1ps

module adc_register_command_decoder (
    input  wire logic                           clk_sys,
    input  wire logic                           rstn,
    input  wire logic                           word_valid,
    input  wire cmd_decoder_pkg::command_word_s word_in,
    input  wire logic                           self_detect_fail,
    input  wire logic                           convert_start_pulse,
    input  wire logic                           pair_done,
    input  wire logic                           stack_end_marker,
    output logic                                write_strobe,
    output logic [5:0]                          write_select,
    output logic [8:0]                          write_data,
    output cmd_decoder_pkg::read_target_e       read_target,
    output logic [5:0]                          read_select,
    output logic [15:0]                         config_readback,
    output cmd_decoder_pkg::config_s            config_out,
    output logic                                append_status,
    output logic [7:0]                          oversampling_ratio,
    output logic                                convert_pair_request,
    output logic                                burst_active
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] sdf_sync;
    logic [1:0] cnv_sync;
    logic       cnv_prev;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sdf_sync <= 2'h0;
            cnv_sync <= 2'h0;
            cnv_prev <= 1'b0;
        end else begin
            sdf_sync <= {sdf_sync[0], self_detect_fail};
            cnv_sync <= {cnv_sync[0], convert_start_pulse};
            cnv_prev <= cnv_sync[1];
        end
    end

    logic cnv_rise;
    assign cnv_rise = cnv_sync[1] & ~cnv_prev;

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    logic       is_write;
    logic       is_stack;
    logic [4:0] low_sel;
    logic       sel_config;

    assign is_write   = word_in.write_flag;
    assign is_stack   = word_in.register_select[5];
    assign low_sel    = word_in.register_select[4:0];
    assign sel_config = !is_stack && (low_sel == cmd_decoder_pkg::SEL_CONFIG);

    cmd_decoder_pkg::config_s      cfg;
    cmd_decoder_pkg::config_s      next_cfg;
    cmd_decoder_pkg::read_target_e next_read_target;
    logic [5:0]                    next_read_select;
    logic                          next_write_strobe;
    logic [5:0]                    next_write_select;
    logic [8:0]                    next_write_data;

    always_comb begin
        next_cfg          = cfg;
        next_read_target  = read_target;
        next_read_select  = read_select;
        next_write_strobe = 1'b0;
        next_write_select = write_select;
        next_write_data   = write_data;
        if (word_valid) begin
            if (is_write) begin
                // reserved code and status are read-only targets: no strobe
                if (is_stack || (low_sel >= cmd_decoder_pkg::SEL_CONFIG
                        && low_sel <= cmd_decoder_pkg::SEL_RANGE_B2)) begin
                    next_write_strobe = 1'b1;
                    next_write_select = word_in.register_select;
                    next_write_data   = word_in.data;
                end
                if (sel_config) begin
                    // bit 7 is dropped so the flag stays hardware-owned
                    next_cfg = word_in.data[6:0];
                end
            end else begin
                next_read_select = word_in.register_select;
                if (is_stack) begin
                    next_read_target = cmd_decoder_pkg::READ_STACK;
                end else if (low_sel == cmd_decoder_pkg::SEL_CONVERSION) begin
                    next_read_target = cmd_decoder_pkg::READ_RESULT;
                end else begin
                    next_read_target = cmd_decoder_pkg::READ_REGISTER;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cfg          <= cmd_decoder_pkg::CFG_RESET;
            read_target  <= cmd_decoder_pkg::READ_NONE;
            read_select  <= 6'h00;
            write_strobe <= 1'b0;
            write_select <= 6'h00;
            write_data   <= 9'h000;
        end else begin
            cfg          <= next_cfg;
            read_target  <= next_read_target;
            read_select  <= next_read_select;
            write_strobe <= next_write_strobe;
            write_select <= next_write_select;
            write_data   <= next_write_data;
        end
    end

    // ----------------------------------------------------------------
    // configuration outputs
    // ----------------------------------------------------------------
    assign config_out = cfg;
    // readback image: address 0x02 in bits 15..9, reserved zero, flag from pin
    assign config_readback = {2'h0, cmd_decoder_pkg::SEL_CONFIG, 1'b0,
                              sdf_sync[1], cfg};

    // decoded from next_cfg so the registered outputs move with cfg
    logic [7:0] next_oversampling_ratio;
    logic       next_append_status;

    always_comb begin
        next_append_status = next_cfg.status_append_enable
                           | next_cfg.checksum_append_enable;
        case (next_cfg.oversampling_ratio_field)
            3'h0:    next_oversampling_ratio = 8'h01;
            3'h1:    next_oversampling_ratio = 8'h02;
            3'h2:    next_oversampling_ratio = 8'h04;
            3'h3:    next_oversampling_ratio = 8'h08;
            3'h4:    next_oversampling_ratio = 8'h10;
            3'h5:    next_oversampling_ratio = 8'h20;
            3'h6:    next_oversampling_ratio = 8'h40;
            default: next_oversampling_ratio = 8'h80;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            oversampling_ratio <= 8'h01;
            append_status      <= 1'b0;
        end else begin
            oversampling_ratio <= next_oversampling_ratio;
            append_status      <= next_append_status;
        end
    end

    // ----------------------------------------------------------------
    // conversion sequencing
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'h0,
        SEQ_PAIR = 2'h1,
        SEQ_NEXT = 2'h3
    } seq_state_e;

    seq_state_e seq_state;
    seq_state_e next_seq_state;
    logic       next_convert_pair_request;
    logic       next_burst_active;

    always_comb begin
        next_seq_state            = seq_state;
        next_convert_pair_request = 1'b0;
        next_burst_active         = burst_active;
        case (seq_state)
            SEQ_IDLE: begin
                if (cnv_rise) begin
                    next_convert_pair_request = 1'b1;
                    next_burst_active = cfg.burst_sequence_enable;
                    next_seq_state = SEQ_PAIR;
                end
            end
            SEQ_PAIR: begin
                if (pair_done) begin
                    if (burst_active && !stack_end_marker) begin
                        next_seq_state = SEQ_NEXT;
                    end else begin
                        next_burst_active = 1'b0;
                        next_seq_state = SEQ_IDLE;
                    end
                end
            end
            SEQ_NEXT: begin
                next_convert_pair_request = 1'b1;
                next_seq_state = SEQ_PAIR;
            end
            default: next_seq_state = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            seq_state            <= SEQ_IDLE;
            convert_pair_request <= 1'b0;
            burst_active         <= 1'b0;
        end else begin
            seq_state            <= next_seq_state;
            convert_pair_request <= next_convert_pair_request;
            burst_active         <= next_burst_active;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_write_strobe;
        @(posedge clk_sys) disable iff (!rstn)
        word_valid && word_in.write_flag && sel_config |=> write_strobe
            && write_select == 6'h02;
    endproperty
    a_write_strobe: assert property (p_write_strobe) else $error("write not strobed");

    property p_read_queue;
        @(posedge clk_sys) disable iff (!rstn)
        word_valid && !word_in.write_flag |=> read_select == $past(word_in.register_select);
    endproperty
    a_read_queue: assert property (p_read_queue) else $error("read not queued");

    property p_stack_read;
        @(posedge clk_sys) disable iff (!rstn)
        word_valid && !word_in.write_flag && word_in.register_select[5]
            |=> read_target == cmd_decoder_pkg::READ_STACK;
    endproperty
    a_stack_read: assert property (p_stack_read) else $error("stack read wrong");

    property p_result_read;
        @(posedge clk_sys) disable iff (!rstn)
        word_valid && !word_in.write_flag && word_in.register_select == 6'h00
            |=> read_target == cmd_decoder_pkg::READ_RESULT;
    endproperty
    a_result_read: assert property (p_result_read) else $error("result read wrong");

    property p_no_reserved_write;
        @(posedge clk_sys) disable iff (!rstn)
        word_valid && word_in.register_select == 6'h01 |=> !write_strobe;
    endproperty
    a_no_reserved_write: assert property (p_no_reserved_write) else $error("reserved written");

    property p_config_load;
        @(posedge clk_sys) disable iff (!rstn)
        word_valid && word_in.write_flag && sel_config
            |=> config_readback[6:0] == $past(word_in.data[6:0])
            && config_readback[15:9] == 7'h02 && !config_readback[8];
    endproperty
    a_config_load: assert property (p_config_load) else $error("config not loaded");

    property p_flag_kept;
        @(posedge clk_sys) disable iff (!rstn)
        word_valid && word_in.write_flag && sel_config ##1 $stable(sdf_sync[1])
            |-> $stable(config_readback[7]);
    endproperty
    a_flag_kept: assert property (p_flag_kept) else $error("flag changed by write");

    property p_append;
        @(posedge clk_sys) disable iff (!rstn)
        word_valid && word_in.write_flag && sel_config
            && (word_in.data[1] || word_in.data[0]) |=> append_status;
    endproperty
    a_append: assert property (p_append) else $error("append missing");

    property p_os_ratio;
        @(posedge clk_sys) disable iff (!rstn)
        word_valid && word_in.write_flag && sel_config
            |=> oversampling_ratio == (8'h01 << $past(word_in.data[4:2]));
    endproperty
    a_os_ratio: assert property (p_os_ratio) else $error("ratio wrong");

    property p_burst_start;
        @(posedge clk_sys) disable iff (!rstn)
        seq_state == SEQ_IDLE && cnv_rise |=> convert_pair_request
            && burst_active == $past(cfg.burst_sequence_enable);
    endproperty
    a_burst_start: assert property (p_burst_start) else $error("start wrong");

    property p_single_pair;
        @(posedge clk_sys) disable iff (!rstn)
        seq_state == SEQ_PAIR && !burst_active && pair_done |=> seq_state == SEQ_IDLE
            && !convert_pair_request;
    endproperty
    a_single_pair: assert property (p_single_pair) else $error("extra pair");

    property p_burst_next;
        @(posedge clk_sys) disable iff (!rstn)
        seq_state == SEQ_PAIR && burst_active && pair_done && !stack_end_marker
            |=> ##1 convert_pair_request;
    endproperty
    a_burst_next: assert property (p_burst_next) else $error("burst stalled");

endmodule // adc_register_command_decoder

//--- test/conv_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// converter side: answers each pair request after DELAY cycles
// ----------------------------------------------------------------
module conv_model #(
    parameter int LAYERS = 3,
    parameter int DELAY  = 4
) (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic convert_pair_request,
    output logic      pair_done,
    output logic      stack_end_marker
);
    int   wait_cnt;
    int   layer;
    logic last_mark;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wait_cnt  <= 0;
            layer     <= 0;
            pair_done <= 1'b0;
            last_mark <= 1'b0;
        end else begin
            pair_done <= 1'b0;
            if (convert_pair_request) begin
                wait_cnt <= DELAY;
            end else if (wait_cnt != 0) begin
                wait_cnt <= wait_cnt - 1;
                if (wait_cnt == 1) begin
                    pair_done <= 1'b1;
                    last_mark <= (layer == LAYERS - 1);
                    layer     <= (layer == LAYERS - 1) ? 0 : layer + 1;
                end
            end
        end
    end

    // marker means nothing away from pair_done, so it shows the inverse there
    assign stack_end_marker = pair_done ? last_mark : ~last_mark;
endmodule // conv_model

//--- test/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    logic                           clk_sys = 1'b0;
    logic                           rstn = 1'b0;
    logic                           word_valid = 1'b0;
    cmd_decoder_pkg::command_word_s word_in = '0;
    logic                           self_detect_fail = 1'b0;
    logic                           convert_start_pulse = 1'b0;
    logic                           pair_done, stack_end_marker, write_strobe;
    logic [5:0]                     write_select, read_select;
    logic [8:0]                     write_data;
    cmd_decoder_pkg::read_target_e  read_target;
    logic [15:0]                    config_readback;
    cmd_decoder_pkg::config_s       config_out;
    logic                           append_status, convert_pair_request, burst_active;
    logic [7:0]                     oversampling_ratio;
    int                             n_errors = 0;
    int                             checked = 0;
    int                             n_req = 0;
    int                             cycles = 0;

    adc_register_command_decoder DUT (
        .clk_sys, .rstn, .word_valid, .word_in, .self_detect_fail,
        .convert_start_pulse, .pair_done, .stack_end_marker, .write_strobe,
        .write_select, .write_data, .read_target, .read_select, .config_readback,
        .config_out, .append_status, .oversampling_ratio, .convert_pair_request,
        .burst_active);
    conv_model u_conv (.clk_sys, .rstn, .convert_pair_request, .pair_done, .stack_end_marker);

    always #25 clk_sys = ~clk_sys;

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // word is taken at the edge after launch; registered outputs update on that same edge
    task automatic send(input logic w, input logic [5:0] sel, input logic [8:0] d);
        @(posedge clk_sys);
        word_valid <= 1'b1;
        word_in    <= {w, sel, d};
        @(posedge clk_sys);
        word_valid <= 1'b0;
        #1;
    endtask

    always @(posedge clk_sys) begin
        if (convert_pair_request === 1'b1) n_req++;
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        chk(config_readback, 16'h0400);
        chk(16'(config_out), 16'h0000);
        chk(16'(read_target), 16'h0000);
        $display("test reset done");
    endtask

    task automatic t_config();
        send(1'b1, 6'h02, 9'h1FF);
        chk(16'(write_strobe), 16'h0001);
        chk(16'(config_out), 16'h007F);
        chk(config_readback, 16'h047F);
        @(posedge clk_sys);
        self_detect_fail <= 1'b1;
        repeat (4) @(posedge clk_sys);
        send(1'b1, 6'h02, 9'h000);
        chk(config_readback, 16'h0480);
        @(posedge clk_sys);
        self_detect_fail <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        chk(config_readback, 16'h0400);
        $display("test config done");
    endtask

    task automatic t_fields();
        for (int i = 0; i < 8; i++) begin
            send(1'b1, 6'h02, {4'h0, i[2:0], 2'b00});
            chk(16'(oversampling_ratio), 16'h0001 << i);
        end
        for (int j = 0; j < 4; j++) begin
            send(1'b1, 6'h02, {7'h00, j[1:0]});
            chk(16'(append_status), 16'(j != 0));
        end
        $display("test fields done");
    endtask

    task automatic t_decode();
        send(1'b0, 6'h00, 9'h000);
        chk(16'(read_target), 16'(cmd_decoder_pkg::READ_RESULT));
        send(1'b0, 6'h03, 9'h000);
        chk(16'(read_target), 16'(cmd_decoder_pkg::READ_REGISTER));
        chk(16'(read_select), 16'h0003);
        send(1'b0, 6'h25, 9'h000);
        chk(16'(read_target), 16'(cmd_decoder_pkg::READ_STACK));
        chk(16'(read_select), 16'h0025);
        send(1'b1, 6'h01, 9'h155);
        chk(16'(write_strobe), 16'h0000);
        send(1'b1, 6'h08, 9'h155);
        chk(16'(write_strobe), 16'h0000);
        send(1'b1, 6'h03, 9'h0AA);
        chk({write_strobe, write_select, write_data}, 16'h86AA);
        chk(16'(config_out), 16'h0003);
        send(1'b1, 6'h3F, 9'h101);
        chk({write_strobe, write_select, write_data}, 16'hFF01);
        $display("test decode done");
    endtask

    // one start pulse; the converter model ends the stack after three layers
    task automatic t_conv(input logic [8:0] cfg, input int exp_n, input logic exp_burst);
        send(1'b1, 6'h02, cfg);
        chk(16'(config_out), 16'(cfg[6:0]));
        n_req = 0;
        @(posedge clk_sys);
        convert_start_pulse <= 1'b1;
        repeat (10) @(posedge clk_sys);
        #1;
        chk(16'(burst_active), 16'(exp_burst));
        repeat (50) @(posedge clk_sys);
        convert_start_pulse <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(16'(n_req), 16'(exp_n));
        $display("test convert done");
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        #1;
        t_reset();
        t_config();
        t_fields();
        t_decode();
        t_conv(9'h060, 3, 1'b1);
        t_conv(9'h020, 1, 1'b0);
        end_sim();
    end
endmodule // tb_top
